// file: logic/watchdog_pkg.sv
//***************************************************************
// watchdog unit constants
//***************************************************************
package watchdog_pkg;

    // register addresses
    localparam logic [15:0] CTRL_STATUS_ADDR = 16'hffa8;
    localparam logic [15:0] COUNTER_ADDR = 16'hffa9;
    // shared word write address (upper byte lane first)
    localparam logic [15:0] WRITE_WORD_ADDR = 16'hffa8;

    // write passwords in the upper byte
    localparam logic [7:0] COUNTER_PASSWORD = 8'h5a;
    localparam logic [7:0] CTRL_PASSWORD = 8'ha5;

    // control/status field positions
    localparam int OVF_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int RUN_BIT = 5;
    localparam int FIXED_ONE_BIT = 4;
    localparam int ACTION_BIT = 3;
    localparam int DIV_LSB = 0;
    localparam int DIV_WIDTH = 3;

    // reset values and counter rollover value
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 3'h0;
    localparam logic [7:0] COUNTER_ALL_ONES = 8'hff;

    // prescaler
    localparam int PRESCALE_WIDTH = 12;
    // log2 of divider per select code: 2,32,64,128,256,512,2048,4096
    localparam logic [3:0] DIV_LOG2 [0:7] = '{
        4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc
    };

    // chip reset hold in system clocks
    localparam int RESET_HOLD_CYCLES = 518;

    // overflow flag clear handshake
    typedef enum logic [2:0] {
        FLAG_LOW = 3'b001,
        FLAG_SET = 3'b010,
        FLAG_ARMED = 3'b100
    } flag_state_type;

endpackage : watchdog_pkg

// file: logic/tick_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
//***************************************************************
// free-running prescaler, one tick pulse per selected period
//***************************************************************
module tick_prescaler
    import watchdog_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [DIV_WIDTH-1:0] div_select,
    output logic tick
);

    logic [PRESCALE_WIDTH-1:0] count_reg;
    logic [PRESCALE_WIDTH-1:0] count_next;
    logic tick_reg;
    logic tick_next;
    logic [PRESCALE_WIDTH-1:0] mask;

    always_comb begin
        mask = '0;
        for (int i = 0; i < PRESCALE_WIDTH; i++) begin
            if (i < int'(DIV_LOG2[div_select])) begin
                mask[i] = 1'b1;
            end
        end
        // wraps freely, so each setting gives a steady period
        count_next = count_reg + 1'b1;
        // tick when the low bits wrap: period is 2^n clocks
        tick_next = ((count_reg & mask) == mask);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : tick_prescaler
`default_nettype wire

// file: logic/reset_stretcher.sv
`timescale 1ns/1ps
`default_nettype none
//***************************************************************
// holds the chip reset request for a fixed number of clocks
//***************************************************************
module reset_stretcher #(
    parameter int HOLD_CYCLES = 518
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fire,
    output logic chip_reset
);

    localparam int CW = $clog2(HOLD_CYCLES + 1);

    initial begin
        if (HOLD_CYCLES < 1) begin
            $error("HOLD_CYCLES must be at least 1");
        end
    end

    logic [CW-1:0] left_reg;
    logic [CW-1:0] left_next;
    logic out_reg;
    logic out_next;

    always_comb begin
        left_next = left_reg;
        if (fire && left_reg == '0) begin
            left_next = CW'(HOLD_CYCLES);
        end else if (left_reg != '0) begin
            left_next = left_reg - 1'b1;
        end
        out_next = (left_next != '0);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            left_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            left_reg <= left_next;
            out_reg <= out_next;
        end
    end

    assign chip_reset = out_reg;

endmodule : reset_stretcher
`default_nettype wire

// file: logic/watchdog_interval_timer.sv
//Operation
//- action bit 0 asks non-maskable interrupt, 1 asks chip reset on overflow in watchdog mode
//- run enable low holds counter at zero; high lets it count ticks
//- overflow sets flag; clear needs read as one then write zero
//- three-bit select picks clock divided by 2..4096
//- interval mode requests repeat every full count period
//- only word writes reach counter or control; byte writes ignored
//- one write address; 0x5a loads counter, 0xa5 control, else dropped
//- byte reads: control at 0xffa8, counter at 0xffa9
//- watchdog mode when mode bit and run bit both one
//- watchdog overflow holds chip reset 518 clocks or asks NMI
//- watchdog NMI shares the pin NMI vector
//- watchdog reset records its cause in a status flag
//- interval mode requests an interrupt at every overflow
//- flag set in the same cycle as the request
//- counter write wins over a coinciding tick
//- standby recovery clears counter and control except divider
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer
    import watchdog_pkg::*;
#(
    parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr_strobe,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_rd_strobe,
    output logic [7:0] bus_rdata,
    input wire logic standby_recover,
    output logic chip_reset_req,
    output logic nmi_req,
    output logic interval_irq,
    output logic reset_cause_flag
);

    //***********************************************************
    // elaboration checks
    //***********************************************************
    initial begin
        if (HOLD_CYCLES < 1) begin
            $error("HOLD_CYCLES must be at least 1");
        end
        // the prescaler must reach the slowest tick
        if (int'(DIV_LOG2[7]) > PRESCALE_WIDTH) begin
            $error("prescaler narrower than the slowest divider");
        end
        if (DIV_WIDTH != 3) begin
            $error("divider select must be three bits wide");
        end
    end

    //***********************************************************
    // register state
    //***********************************************************
    logic [7:0] watchdog_counter_reg;
    logic [7:0] watchdog_counter_next;
    logic watchdog_or_interval_select_reg;
    logic watchdog_or_interval_select_next;
    logic timer_run_enable_reg;
    logic timer_run_enable_next;
    logic overflow_action_reg;
    logic overflow_action_next;
    logic [DIV_WIDTH-1:0] tick_divider_select_reg;
    logic [DIV_WIDTH-1:0] tick_divider_select_next;
    flag_state_type flag_state_reg;
    flag_state_type flag_state_next;
    logic [7:0] bus_rdata_reg;
    logic [7:0] bus_rdata_next;
    logic nmi_req_reg;
    logic nmi_req_next;
    logic interval_irq_reg;
    logic interval_irq_next;
    logic reset_cause_flag_reg;
    logic reset_cause_flag_next;

    logic tick;
    logic overflow_flag;
    logic write_ok;
    logic counter_write;
    logic ctrl_write;
    logic overflow;
    logic watchdog_mode;
    logic fire_reset;
    logic [7:0] ctrl_status_view;
    logic [7:0] payload;
    logic status_read;
    logic interval_mode;

    //***********************************************************
    // tick source and reset hold
    //***********************************************************
    tick_prescaler u_prescaler (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .div_select(tick_divider_select_reg),
        .tick(tick)
    );

    reset_stretcher #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_stretcher (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fire(fire_reset),
        .chip_reset(chip_reset_req)
    );

    //***********************************************************
    // bus decode
    //***********************************************************
    always_comb begin
        payload = bus_wdata[7:0];
        // word write to the shared address only
        write_ok = bus_wr_strobe && bus_word &&
                   (bus_addr == WRITE_WORD_ADDR);
        // password in the upper byte selects the target
        counter_write = write_ok && (bus_wdata[15:8] == COUNTER_PASSWORD);
        ctrl_write = write_ok && (bus_wdata[15:8] == CTRL_PASSWORD);
        status_read = bus_rd_strobe && (bus_addr == CTRL_STATUS_ADDR);
        overflow_flag = (flag_state_reg != FLAG_LOW);
        interval_mode = !watchdog_or_interval_select_reg &&
                        timer_run_enable_reg;
        watchdog_mode = watchdog_or_interval_select_reg &&
                        timer_run_enable_reg;
        ctrl_status_view = '0;
        ctrl_status_view[OVF_BIT] = overflow_flag;
        ctrl_status_view[MODE_BIT] = watchdog_or_interval_select_reg;
        ctrl_status_view[RUN_BIT] = timer_run_enable_reg;
        ctrl_status_view[FIXED_ONE_BIT] = 1'b1;
        ctrl_status_view[ACTION_BIT] = overflow_action_reg;
        ctrl_status_view[DIV_LSB +: DIV_WIDTH] = tick_divider_select_reg;
    end

    //***********************************************************
    // counter
    //***********************************************************
    always_comb begin
        watchdog_counter_next = watchdog_counter_reg;
        // rollover from all ones; a write or standby recovery wins
        overflow = tick && timer_run_enable_reg && !counter_write &&
                   !standby_recover &&
                   (watchdog_counter_reg == COUNTER_ALL_ONES);
        if (standby_recover) begin
            watchdog_counter_next = COUNTER_RESET;
        end else if (!timer_run_enable_reg) begin
            watchdog_counter_next = COUNTER_RESET;
        end else if (counter_write) begin
            watchdog_counter_next = payload;
        end else if (tick) begin
            watchdog_counter_next = watchdog_counter_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_counter_reg <= COUNTER_RESET;
        end else begin
            watchdog_counter_reg <= watchdog_counter_next;
        end
    end

    //***********************************************************
    // control/status bits
    //***********************************************************
    always_comb begin
        watchdog_or_interval_select_next = watchdog_or_interval_select_reg;
        timer_run_enable_next = timer_run_enable_reg;
        overflow_action_next = overflow_action_reg;
        tick_divider_select_next = tick_divider_select_reg;
        if (standby_recover) begin
            // divider select keeps its value
            watchdog_or_interval_select_next = 1'b0;
            timer_run_enable_next = 1'b0;
            overflow_action_next = 1'b0;
        end else if (ctrl_write) begin
            watchdog_or_interval_select_next = payload[MODE_BIT];
            timer_run_enable_next = payload[RUN_BIT];
            overflow_action_next = payload[ACTION_BIT];
            tick_divider_select_next =
                payload[DIV_LSB +: DIV_WIDTH];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_or_interval_select_reg <= 1'b0;
            timer_run_enable_reg <= 1'b0;
            overflow_action_reg <= 1'b0;
            tick_divider_select_reg <= DIV_RESET;
        end else begin
            watchdog_or_interval_select_reg <=
                watchdog_or_interval_select_next;
            timer_run_enable_reg <= timer_run_enable_next;
            overflow_action_reg <= overflow_action_next;
            tick_divider_select_reg <= tick_divider_select_next;
        end
    end

    //***********************************************************
    // overflow flag with read-then-write-zero clear
    //***********************************************************
    always_comb begin
        flag_state_next = flag_state_reg;
        case (flag_state_reg)
            FLAG_LOW: begin
                if (overflow) begin
                    flag_state_next = FLAG_SET;
                end
            end
            FLAG_SET: begin
                // a read that sees the flag set arms the clear
                if (status_read) begin
                    flag_state_next = FLAG_ARMED;
                end
            end
            FLAG_ARMED: begin
                // writing one leaves the flag; new overflow beats the clear
                if (ctrl_write && !payload[OVF_BIT] && !overflow) begin
                    flag_state_next = FLAG_LOW;
                end else if (overflow) begin
                    flag_state_next = FLAG_SET;
                end
            end
            default: begin
                flag_state_next = FLAG_LOW;
            end
        endcase
        if (standby_recover) begin
            flag_state_next = FLAG_LOW;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_state_reg <= FLAG_LOW;
        end else begin
            flag_state_reg <= flag_state_next;
        end
    end

    //***********************************************************
    // overflow requests
    //***********************************************************
    always_comb begin
        // all requests leave on the same edge as the flag
        fire_reset = overflow && watchdog_mode &&
                     overflow_action_reg;
        // NMI goes to the shared pin NMI vector
        nmi_req_next = overflow && watchdog_mode &&
                       !overflow_action_reg;
        // every rollover in interval mode, so repeats each period
        interval_irq_next = overflow && interval_mode;
        reset_cause_flag_next = reset_cause_flag_reg || fire_reset;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_req_reg <= 1'b0;
            interval_irq_reg <= 1'b0;
            reset_cause_flag_reg <= 1'b0;
        end else begin
            nmi_req_reg <= nmi_req_next;
            interval_irq_reg <= interval_irq_next;
            reset_cause_flag_reg <= reset_cause_flag_next;
        end
    end

    //***********************************************************
    // read data
    //***********************************************************
    always_comb begin
        bus_rdata_next = bus_rdata_reg;
        if (bus_rd_strobe) begin
            if (bus_addr == CTRL_STATUS_ADDR) begin
                bus_rdata_next = ctrl_status_view;
            end else if (bus_addr == COUNTER_ADDR) begin
                bus_rdata_next = watchdog_counter_reg;
            end else begin
                bus_rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata_reg <= 8'h00;
        end else begin
            bus_rdata_reg <= bus_rdata_next;
        end
    end

    assign bus_rdata = bus_rdata_reg;
    assign nmi_req = nmi_req_reg;
    assign interval_irq = interval_irq_reg;
    assign reset_cause_flag = reset_cause_flag_reg;

endmodule : watchdog_interval_timer
`default_nettype wire

// file: sim/watchdog_interval_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
//****************************************
// port checker
//****************************************
module watchdog_interval_timer_chk
    import watchdog_pkg::*;
#(
    parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr_strobe,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_rd_strobe,
    input wire logic [7:0] bus_rdata,
    input wire logic standby_recover,
    input wire logic chip_reset_req,
    input wire logic nmi_req,
    input wire logic interval_irq,
    input wire logic reset_cause_flag
);
    int rst_len_reg;
    int rst_len_next;
    // length of the current chip reset request
    always_comb begin
        rst_len_next = chip_reset_req ? rst_len_reg + 1 : 0;
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_len_reg <= 0;
        end else begin
            rst_len_reg <= rst_len_next;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_NMI_PULSE: assert property (nmi_req |=> !nmi_req)
        else $error("nmi request longer than one cycle");
    AST_IRQ_PULSE: assert property (interval_irq |=> !interval_irq)
        else $error("interval request longer than one cycle");
    AST_ONE_ACTION: assert property (interval_irq |-> !nmi_req && !$rose(chip_reset_req))
        else $error("more than one overflow action");
    AST_RST_LEN: assert property ($fell(chip_reset_req) |-> rst_len_reg == HOLD_CYCLES)
        else $error("chip reset hold length wrong");
    AST_RST_MAX: assert property (chip_reset_req |-> rst_len_reg < HOLD_CYCLES)
        else $error("chip reset held too long");
    AST_CAUSE_SET: assert property ($rose(chip_reset_req) |-> reset_cause_flag)
        else $error("reset cause not recorded");
    AST_CAUSE_KEEP: assert property (reset_cause_flag |=> reset_cause_flag)
        else $error("reset cause lost");
    AST_RDATA_HOLD: assert property (!$past(bus_rd_strobe) |-> $stable(bus_rdata))
        else $error("read data changed without read");
    AST_UNMAPPED: assert property (bus_rd_strobe && bus_addr != CTRL_STATUS_ADDR
        && bus_addr != COUNTER_ADDR |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_FIXED_ONE: assert property (bus_rd_strobe && bus_addr == CTRL_STATUS_ADDR
        |=> bus_rdata[FIXED_ONE_BIT])
        else $error("fixed bit not one");
endmodule : watchdog_interval_timer_chk
bind watchdog_interval_timer watchdog_interval_timer_chk #(
    .HOLD_CYCLES(HOLD_CYCLES)
) chk_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wr_strobe(bus_wr_strobe), .bus_word(bus_word),
    .bus_wdata(bus_wdata), .bus_rd_strobe(bus_rd_strobe),
    .bus_rdata(bus_rdata), .standby_recover(standby_recover),
    .chip_reset_req(chip_reset_req), .nmi_req(nmi_req),
    .interval_irq(interval_irq), .reset_cause_flag(reset_cause_flag)
);
`default_nettype wire

// file: sim/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
//****************************************
// cpu side of the register bus
//****************************************
module cpu_bus_model
    import watchdog_pkg::*;
(
    input wire logic core_clk,
    output logic [15:0] bus_addr,
    output logic bus_wr_strobe,
    output logic bus_word,
    output logic [15:0] bus_wdata,
    output logic bus_rd_strobe,
    input wire logic [7:0] bus_rdata
);
    initial begin
        bus_addr = 16'h0000;
        bus_wr_strobe = 1'b0;
        bus_word = 1'b0;
        bus_wdata = 16'h0000;
        bus_rd_strobe = 1'b0;
    end
    // released lines show the inverse of the last value
    task automatic wr(input logic w, input logic [15:0] a,
                      input logic [15:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_word <= w;
        bus_wdata <= d;
        bus_wr_strobe <= 1'b1;
        @(posedge core_clk);
        bus_wr_strobe <= 1'b0;
        bus_addr <= ~a;
        bus_word <= ~w;
        bus_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd_strobe <= 1'b1;
        @(posedge core_clk);
        bus_rd_strobe <= 1'b0;
        bus_addr <= ~a;
        #1;
        q = bus_rdata;
    endtask : rd
    task automatic ctrl(input logic [7:0] v);
        wr(1'b1, WRITE_WORD_ADDR, {CTRL_PASSWORD, v});
    endtask : ctrl
    task automatic cnt(input logic [7:0] v);
        wr(1'b1, WRITE_WORD_ADDR, {COUNTER_PASSWORD, v});
    endtask : cnt
endmodule : cpu_bus_model
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import watchdog_pkg::*;
;
    localparam int HOLD = 4;
    logic core_clk;
    logic sys_rst;
    logic standby_recover;
    logic [15:0] bus_addr, bus_wdata;
    logic bus_wr_strobe, bus_word, bus_rd_strobe;
    logic [7:0] bus_rdata, q;
    logic chip_reset_req, nmi_req, interval_irq, reset_cause_flag;
    logic [2:0] evs;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int t0, n;
    int per [0:7] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    assign evs = {chip_reset_req, nmi_req, interval_irq};
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    watchdog_interval_timer #(.HOLD_CYCLES(HOLD)) watchdog_interval_timer_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wr_strobe(bus_wr_strobe), .bus_word(bus_word),
        .bus_wdata(bus_wdata), .bus_rd_strobe(bus_rd_strobe),
        .bus_rdata(bus_rdata), .standby_recover(standby_recover),
        .chip_reset_req(chip_reset_req), .nmi_req(nmi_req),
        .interval_irq(interval_irq), .reset_cause_flag(reset_cause_flag));
    cpu_bus_model cpu_bus_model_inst (
        .core_clk(core_clk), .bus_addr(bus_addr),
        .bus_wr_strobe(bus_wr_strobe), .bus_word(bus_word),
        .bus_wdata(bus_wdata), .bus_rd_strobe(bus_rd_strobe),
        .bus_rdata(bus_rdata));
    //****************************************
    // helpers
    //****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        cpu_bus_model_inst.rd(a, q);
        chk({24'h0, q}, {24'h0, exp});
    endtask : rd_chk
    // bounded wait for reset, nmi or interval request
    task automatic wait_hi(input int sel);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (n < 9000 && evs[sel] !== 1'b1);
        chk(n < 9000, 1);
    endtask : wait_hi
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    //****************************************
    // tests
    //****************************************
    initial begin
        #(70000 * 40);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        sys_rst = 1'b1;
        standby_recover = 1'b0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(CTRL_STATUS_ADDR, 8'h10);
        rd_chk(COUNTER_ADDR, 8'h00);
        rd_chk(16'hffaa, 8'h00);
        cpu_bus_model_inst.ctrl(8'h27);
        rd_chk(CTRL_STATUS_ADDR, 8'h37);
        cpu_bus_model_inst.cnt(8'h37);
        rd_chk(COUNTER_ADDR, 8'h37);
        cpu_bus_model_inst.wr(1'b0, WRITE_WORD_ADDR, 16'h5a55);
        cpu_bus_model_inst.wr(1'b1, WRITE_WORD_ADDR, 16'h5b55);
        cpu_bus_model_inst.wr(1'b1, WRITE_WORD_ADDR, 16'ha455);
        rd_chk(COUNTER_ADDR, 8'h37);
        cpu_bus_model_inst.ctrl(8'h07);
        rd_chk(COUNTER_ADDR, 8'h00);
        for (int k = 0; k < 8; k++) begin
            cpu_bus_model_inst.ctrl(k[7:0]);
            cpu_bus_model_inst.ctrl(8'h20 | k[7:0]);
            cpu_bus_model_inst.cnt(8'hff);
            wait_hi(0);
            t0 = cyc;
            if (k != 0) begin
                cpu_bus_model_inst.cnt(8'hff);
            end
            wait_hi(0);
            chk(cyc - t0, k == 0 ? 512 : per[k]);
        end
        cpu_bus_model_inst.ctrl(8'h27);
        rd_chk(CTRL_STATUS_ADDR, 8'hb7);
        cpu_bus_model_inst.ctrl(8'ha7);
        rd_chk(CTRL_STATUS_ADDR, 8'hb7);
        cpu_bus_model_inst.ctrl(8'h27);
        rd_chk(CTRL_STATUS_ADDR, 8'h37);
        cpu_bus_model_inst.ctrl(8'h07);
        cpu_bus_model_inst.ctrl(8'h67);
        cpu_bus_model_inst.cnt(8'hff);
        wait_hi(1);
        chk({31'h0, chip_reset_req}, 32'h0);
        rd_chk(CTRL_STATUS_ADDR, 8'hf7);
        cpu_bus_model_inst.ctrl(8'h07);
        cpu_bus_model_inst.ctrl(8'h6f);
        cpu_bus_model_inst.cnt(8'hff);
        wait_hi(2);
        chk({31'h0, reset_cause_flag}, 32'h1);
        n = 0;
        while (chip_reset_req === 1'b1 && n < 600) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        chk(n, HOLD);
        @(posedge core_clk);
        standby_recover <= 1'b1;
        @(posedge core_clk);
        standby_recover <= 1'b0;
        rd_chk(CTRL_STATUS_ADDR, 8'h17);
        rd_chk(COUNTER_ADDR, 8'h00);
        // writes on both tick phases: one lands on a tick, one does not
        cpu_bus_model_inst.ctrl(8'h20);
        cpu_bus_model_inst.cnt(8'h10);
        cpu_bus_model_inst.rd(COUNTER_ADDR, q);
        t0 = q;
        @(posedge core_clk);
        cpu_bus_model_inst.cnt(8'h10);
        cpu_bus_model_inst.rd(COUNTER_ADDR, q);
        chk(t0 + q, 32'h21);
        cpu_bus_model_inst.ctrl(8'h60);
        repeat (20) begin
            cpu_bus_model_inst.cnt(8'h00);
            repeat (100) @(posedge core_clk);
        end
        rd_chk(CTRL_STATUS_ADDR, 8'h70);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
